// File: pkg/tpfcl_consts.svh
// Timing counts and speed code levels for the two-phase fan commutation block
`ifndef TPFCL_CONSTS_SVH
`define TPFCL_CONSTS_SVH

// Clock rate in kHz (40 MHz)
`define TPFCL_CLK_KHZ 40000
// PWM frequency: 24 kHz typical, in Hz
`define TPFCL_PWM_FREQ_HZ 24000
`define TPFCL_PWM_CYCLES ((`TPFCL_CLK_KHZ * 1000) / `TPFCL_PWM_FREQ_HZ)
// Stall timing in milliseconds
`define TPFCL_STALL_DETECT_MS 714
`define TPFCL_RETRY_ON_MS 330
`define TPFCL_RETRY_OFF_MS 4000
`define TPFCL_MS_CYCLES(ms) ((ms) * `TPFCL_CLK_KHZ)
// Speed code: 8-bit code across 0 V..2 V, 128 per volt
`define TPFCL_SPD_FULL_CODE 8'h80
`define TPFCL_SPD_ZERO_CODE 8'hFF
`define TPFCL_SPD_OPEN_CODE 8'hC0

`endif

// File: pkg/tpfcl_pkg.sv
// Types for the two-phase fan commutation block
package tpfcl_pkg;
  typedef enum logic [1:0] {
    TPFCL_RUN,
    TPFCL_STALL_ON,
    TPFCL_STALL_OFF
  } tpfcl_state_type;

  typedef enum logic [1:0] {
    TPFCL_VAR_COMBINED,
    TPFCL_VAR_STALL_ONLY,
    TPFCL_VAR_TACH_ONLY
  } tpfcl_variant_type;

  typedef enum logic [1:0] {
    TPFCL_SRC_VOLTAGE,
    TPFCL_SRC_OPEN,
    TPFCL_SRC_EXTERNAL
  } tpfcl_source_type;
endpackage : tpfcl_pkg

// File: src/tpfcl_ramp.sv
`timescale 1ns/1ps
// Ramp timer shared by the PWM carrier and the stall timer
module tpfcl_ramp #(
  parameter int WIDTH = 28
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic restart_i,
  input wire logic [WIDTH-1:0] limit_i,
  // Status
  output logic [WIDTH-1:0] count_o,
  output logic wrap_o
);
  logic [WIDTH-1:0] next_count;
  logic next_wrap;

  always_comb begin
    next_wrap = 1'b0;
    if (restart_i) begin
      next_count = '0;
    end else if (count_o >= limit_i - 1'b1) begin
      next_count = '0;
      next_wrap = 1'b1;
    end else begin
      next_count = count_o + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
      wrap_o <= 1'b0;
    end else begin
      count_o <= next_count;
      wrap_o <= next_wrap;
    end
  end
endmodule : tpfcl_ramp

// File: src/tpfcl_core.sv
`timescale 1ns/1ps
`include "tpfcl_consts.svh"
// Two-phase fan commutation, speed PWM and stall retry core
// How it works
// RULE1 - Hall positive above negative selects phase B as the driven output.
// RULE2 - Otherwise phase A drives; never both; PWM gates only the active phase.
// RULE3 - Speed code maps linearly: top of range 0% duty, bottom 100% duty.
// RULE4 - Speed input left open gives the mid code and half duty.
// RULE5 - Speed at or above the zero-drive level forces drive fully off.
// RULE6 - An external PWM input may set phase duty instead.
// RULE7 - Combined variant: output toggles with Hall, twice rotation frequency.
// RULE8 - Combined variant: stall timeout forces output high until rotation resumes.
// RULE9 - Stall-only variant: low normally, high once stall timeout is reached.
// RULE10 - Tach-only variant: output is the inverted Hall comparison.
// RULE11 - While stalled, cycle short drive interval then long idle wait.
// RULE12 - Default retry drive about 0.33 s and wait about 4.0 s.
// RULE13 - Detect delay is full ramp; drive and wait are threshold-to-threshold ramps.
// RULE14 - Every Hall transition restarts the stall timer from zero.
// RULE15 - PWM carrier defaults to about 24 kHz.
// RULE16 - PWM period is one charge ramp plus one discharge ramp.
// RULE17 - Retry drive-to-wait ratio at least one to seven.
module tpfcl_core #(
  parameter int PWM_CYCLES = `TPFCL_PWM_CYCLES,
  parameter int DETECT_CYCLES = `TPFCL_MS_CYCLES(`TPFCL_STALL_DETECT_MS),
  parameter int RETRY_ON_CYCLES = `TPFCL_MS_CYCLES(`TPFCL_RETRY_ON_MS),
  parameter int RETRY_OFF_CYCLES = `TPFCL_MS_CYCLES(`TPFCL_RETRY_OFF_MS),
  parameter tpfcl_pkg::tpfcl_variant_type VARIANT = tpfcl_pkg::TPFCL_VAR_COMBINED
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Hall comparator inputs
  input wire logic hall_pos_in_i,
  input wire logic hall_neg_in_i,
  // Speed command
  input wire tpfcl_pkg::tpfcl_source_type speed_source_i,
  input wire logic [7:0] speed_voltage_in_i,
  input wire logic ext_pwm_in_i,
  // Phase drives
  output logic phase_a_drive_o,
  output logic phase_b_drive_o,
  // Status outputs
  output logic stall_tacho_out_o,
  output logic tacho_pulse_out_o,
  output logic stall_o
);
  localparam int TW = 28;
  localparam logic [7:0] SPAN = `TPFCL_SPD_ZERO_CODE - `TPFCL_SPD_FULL_CODE;

  // Duty in PWM cycles from the speed code, clamped at both ends
  function automatic logic [TW-1:0] duty_of(input logic [7:0] code);
    logic [TW+7:0] prod;
    prod = '0;
    if (code >= `TPFCL_SPD_ZERO_CODE) begin
      duty_of = '0; // RULE5
    end else if (code <= `TPFCL_SPD_FULL_CODE) begin
      duty_of = TW'(PWM_CYCLES); // RULE3
    end else begin
      prod = (TW+8)'(`TPFCL_SPD_ZERO_CODE - code) * (TW+8)'(PWM_CYCLES); // RULE3
      duty_of = TW'(prod / (TW+8)'(SPAN));
    end
  endfunction : duty_of

  tpfcl_pkg::tpfcl_state_type state;
  tpfcl_pkg::tpfcl_state_type next_state;
  logic hall_high;
  logic hall_prev;
  logic hall_edge;
  logic pwm_on;
  logic [7:0] eff_code;
  logic [TW-1:0] pwm_count;
  logic [TW-1:0] stall_count;
  logic [TW-1:0] stall_limit;
  logic stall_restart;
  logic drive_allowed;
  logic next_a;
  logic next_b;
  logic next_st;
  logic next_tp;
  logic next_stall;

  assign hall_high = hall_pos_in_i & ~hall_neg_in_i;
  assign hall_edge = hall_high ^ hall_prev; // RULE14

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hall_prev <= 1'b0;
    end else begin
      hall_prev <= hall_high;
    end
  end

  // PWM carrier: one period covers charge plus discharge ramp
  tpfcl_ramp #(.WIDTH(TW)) u_pwm_ramp (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .restart_i(1'b0),
    .limit_i(TW'(PWM_CYCLES)), // RULE15 RULE16
    .count_o(pwm_count),
    .wrap_o()
  );

  always_comb begin
    eff_code = speed_voltage_in_i;
    if (speed_source_i == tpfcl_pkg::TPFCL_SRC_OPEN) begin
      eff_code = `TPFCL_SPD_OPEN_CODE; // RULE4
    end
  end

  always_comb begin
    if (speed_source_i == tpfcl_pkg::TPFCL_SRC_EXTERNAL) begin
      pwm_on = ext_pwm_in_i; // RULE6
    end else begin
      pwm_on = pwm_count < duty_of(eff_code); // RULE3
    end
  end

  // Stall timer: ramp length depends on the phase of the retry cycle
  always_comb begin
    case (state)
      tpfcl_pkg::TPFCL_RUN: stall_limit = TW'(DETECT_CYCLES); // RULE13
      tpfcl_pkg::TPFCL_STALL_ON: stall_limit = TW'(RETRY_ON_CYCLES); // RULE12
      default: stall_limit = TW'(RETRY_OFF_CYCLES); // RULE12 RULE17
    endcase
  end

  assign stall_restart = hall_edge || (state != next_state);

  tpfcl_ramp #(.WIDTH(TW)) u_stall_ramp (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .restart_i(stall_restart),
    .limit_i(stall_limit),
    .count_o(stall_count),
    .wrap_o()
  );

  // Count is compared directly, so the state changes on the same edge as the timer wraps
  always_comb begin
    next_state = state;
    case (state)
      tpfcl_pkg::TPFCL_RUN: begin
        if (!hall_edge && stall_count >= stall_limit - 1'b1) begin
          next_state = tpfcl_pkg::TPFCL_STALL_ON; // RULE13 RULE14
        end
      end
      tpfcl_pkg::TPFCL_STALL_ON: begin
        if (hall_edge) begin
          next_state = tpfcl_pkg::TPFCL_RUN;
        end else if (stall_count >= stall_limit - 1'b1) begin
          next_state = tpfcl_pkg::TPFCL_STALL_OFF; // RULE11
        end
      end
      default: begin
        if (hall_edge) begin
          next_state = tpfcl_pkg::TPFCL_RUN;
        end else if (stall_count >= stall_limit - 1'b1) begin
          next_state = tpfcl_pkg::TPFCL_STALL_ON; // RULE11
        end
      end
    endcase
  end

  assign drive_allowed = (state != tpfcl_pkg::TPFCL_STALL_OFF);

  always_comb begin
    next_b = hall_high & pwm_on & drive_allowed; // RULE1 RULE2
    next_a = ~hall_high & pwm_on & drive_allowed; // RULE2
    next_stall = (next_state != tpfcl_pkg::TPFCL_RUN);
    next_tp = ~hall_high; // RULE10
    case (VARIANT)
      tpfcl_pkg::TPFCL_VAR_COMBINED: next_st = next_stall | hall_high; // RULE7 RULE8
      tpfcl_pkg::TPFCL_VAR_STALL_ONLY: next_st = next_stall; // RULE9
      default: next_st = ~hall_high; // RULE10
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= tpfcl_pkg::TPFCL_RUN;
      phase_a_drive_o <= 1'b0;
      phase_b_drive_o <= 1'b0;
      stall_tacho_out_o <= 1'b0;
      tacho_pulse_out_o <= 1'b0;
      stall_o <= 1'b0;
    end else begin
      state <= next_state;
      phase_a_drive_o <= next_a;
      phase_b_drive_o <= next_b;
      stall_tacho_out_o <= next_st;
      tacho_pulse_out_o <= next_tp;
      stall_o <= next_stall;
    end
  end
endmodule : tpfcl_core

// File: tb/tpfcl_hall_model.sv
`timescale 1ns/1ps
// Hall sensor model: differential pair toggling while the rotor spins
module tpfcl_hall_model #(
  parameter int HALF = 25
) (
  // Clock and spin control
  input wire logic mclk_i,
  input wire logic spin_i,
  // Differential sensor levels
  output logic hall_pos_o,
  output logic hall_neg_o
);
  int cnt = 0;
  logic lvl = 1'b0;
  // Stopped rotor holds its last magnet position
  always @(negedge mclk_i) begin
    if (spin_i) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) begin
        lvl = !lvl;
      end
    end
  end
  assign hall_pos_o = lvl;
  assign hall_neg_o = !lvl;
endmodule : tpfcl_hall_model

// File: tb/tpfcl_chk.sv
`timescale 1ns/1ps
// Checker for commutation, tacho and stall timing at the core ports
module tpfcl_chk #(
  parameter int DETECT_CYCLES = 50,
  parameter tpfcl_pkg::tpfcl_variant_type VARIANT = tpfcl_pkg::TPFCL_VAR_COMBINED
) (
  // Clock, reset and inputs
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hall_pos_in_i,
  input wire logic hall_neg_in_i,
  input wire tpfcl_pkg::tpfcl_source_type speed_source_i,
  input wire logic [7:0] speed_voltage_in_i,
  input wire logic ext_pwm_in_i,
  // Outputs
  input wire logic phase_a_drive_o,
  input wire logic phase_b_drive_o,
  input wire logic stall_tacho_out_o,
  input wire logic tacho_pulse_out_o,
  input wire logic stall_o
);
  localparam bit IS_COMB = VARIANT == tpfcl_pkg::TPFCL_VAR_COMBINED;
  localparam bit IS_STALL = VARIANT == tpfcl_pkg::TPFCL_VAR_STALL_ONLY;
  localparam bit IS_TACH = VARIANT == tpfcl_pkg::TPFCL_VAR_TACH_ONLY;
  logic hh;
  logic hh_d;
  int quiet;
  assign hh = hall_pos_in_i & ~hall_neg_in_i;
  // Cycles since the last hall change
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hh_d <= 1'b0;
      quiet <= 0;
    end else begin
      hh_d <= hh;
      quiet <= (hh != hh_d) ? 0 : quiet + 1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_edge;
    $changed(hh);
  endsequence
  sequence s_quiet_out;
    quiet == DETECT_CYCLES + 3;
  endsequence
  a_b_side: assert property ($past(hh) |-> !phase_a_drive_o)
    else $error("phase A driven while hall high");
  a_a_side: assert property (!$past(hh) |-> !phase_b_drive_o)
    else $error("phase B driven while hall low");
  // Outputs still hold their reset value at the first edge after release
  a_tacho_inv: assert property ($past(rst_n_i) |-> tacho_pulse_out_o == !$past(hh))
    else $error("tacho not inverted hall");
  a_zero_drive: assert property ($past(speed_source_i == tpfcl_pkg::TPFCL_SRC_VOLTAGE
    && speed_voltage_in_i == 8'hFF) |-> !(phase_a_drive_o || phase_b_drive_o))
    else $error("drive on at zero code");
  a_ext_low: assert property ($past(speed_source_i == tpfcl_pkg::TPFCL_SRC_EXTERNAL
    && !ext_pwm_in_i) |-> !(phase_a_drive_o || phase_b_drive_o))
    else $error("drive on with external pwm low");
  a_stall_flag: assert property (IS_COMB && stall_o |-> stall_tacho_out_o)
    else $error("combined output low in stall");
  a_one_phase: assert property (!(phase_a_drive_o && phase_b_drive_o))
    else $error("both phases driven");
  a_comb_tach: assert property (IS_COMB && $past(rst_n_i) && !stall_o
    |-> stall_tacho_out_o == $past(hh))
    else $error("combined output not following hall");
  a_stall_pin: assert property (IS_STALL |-> stall_tacho_out_o == stall_o)
    else $error("stall-only output differs from stall");
  a_tach_pin: assert property (IS_TACH |-> stall_tacho_out_o == tacho_pulse_out_o)
    else $error("tach-only output differs from tacho");
  a_stall_early: assert property (stall_o |-> quiet >= DETECT_CYCLES - 2)
    else $error("stall before detect delay");
  a_stall_due: assert property (s_quiet_out |-> stall_o)
    else $error("stall missing after detect delay");
  a_resume: assert property (s_edge |-> ##[1:3] !stall_o)
    else $error("stall kept after rotation");
endmodule : tpfcl_chk
bind tpfcl_core tpfcl_chk #(.DETECT_CYCLES(DETECT_CYCLES), .VARIANT(VARIANT)) u_chk (.*);

// File: tb/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the fan commutation core
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic spin = 1'b0;
  logic ext = 1'b0;
  logic [7:0] code = 8'h80;
  tpfcl_pkg::tpfcl_source_type src = tpfcl_pkg::TPFCL_SRC_VOLTAGE;
  logic hp, hn, pa, pb, st, tp, so;
  logic st_so, st_to;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 mclk = !mclk;
  tpfcl_hall_model HALL (.mclk_i(mclk), .spin_i(spin), .hall_pos_o(hp), .hall_neg_o(hn));
  tpfcl_core #(.PWM_CYCLES(20), .DETECT_CYCLES(50), .RETRY_ON_CYCLES(10),
    .RETRY_OFF_CYCLES(100)) DUT (.mclk_i(mclk), .rst_n_i(rst_n), .hall_pos_in_i(hp),
    .hall_neg_in_i(hn), .speed_source_i(src), .speed_voltage_in_i(code), .ext_pwm_in_i(ext),
    .phase_a_drive_o(pa), .phase_b_drive_o(pb), .stall_tacho_out_o(st),
    .tacho_pulse_out_o(tp), .stall_o(so));
  // Same stimulus into the other two pin variants
  tpfcl_core #(.PWM_CYCLES(20), .DETECT_CYCLES(50), .RETRY_ON_CYCLES(10),
    .RETRY_OFF_CYCLES(100), .VARIANT(tpfcl_pkg::TPFCL_VAR_STALL_ONLY))
    DUT_SO (.mclk_i(mclk), .rst_n_i(rst_n), .hall_pos_in_i(hp), .hall_neg_in_i(hn),
    .speed_source_i(src), .speed_voltage_in_i(code), .ext_pwm_in_i(ext),
    .phase_a_drive_o(), .phase_b_drive_o(), .stall_tacho_out_o(st_so),
    .tacho_pulse_out_o(), .stall_o());
  tpfcl_core #(.PWM_CYCLES(20), .DETECT_CYCLES(50), .RETRY_ON_CYCLES(10),
    .RETRY_OFF_CYCLES(100), .VARIANT(tpfcl_pkg::TPFCL_VAR_TACH_ONLY))
    DUT_TO (.mclk_i(mclk), .rst_n_i(rst_n), .hall_pos_in_i(hp), .hall_neg_in_i(hn),
    .speed_source_i(src), .speed_voltage_in_i(code), .ext_pwm_in_i(ext),
    .phase_a_drive_o(), .phase_b_drive_o(), .stall_tacho_out_o(st_to),
    .tacho_pulse_out_o(), .stall_o());
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic near(input string what, input int v, input int lo, input int hi);
    check(what, v, (v >= lo && v <= hi) ? v : lo);
  endtask : near
  task automatic results;
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // Spinning rotor: duty count over ten carrier periods, tolerant of hall edges
  task automatic duty(input tpfcl_pkg::tpfcl_source_type s, input logic [7:0] c,
    input logic e, input int exp);
    int on;
    @(negedge mclk);
    src = s;
    code = c;
    ext = e;
    spin = 1'b1;
    repeat (4) @(negedge mclk);
    on = 0;
    repeat (200) begin
      @(negedge mclk);
      on += (pa | pb) ? 1 : 0;
      check("combined", st, !tp);
      check("stall", so, 1'b0);
      check("stall only", st_so, 1'b0);
      check("tach only", st_to, tp);
    end
    near("duty", on, exp - 12, exp + 12);
  endtask : duty
  // Stopped rotor: detect delay, retry wait and drive lengths, then recovery
  task automatic stall;
    int n;
    @(negedge mclk);
    src = tpfcl_pkg::TPFCL_SRC_VOLTAGE;
    code = 8'h80;
    #1;
    // Stop with hall low, so a high combined output can only mean stall
    while (hp !== 1'b1) @(negedge mclk) #1;
    while (hp !== 1'b0) @(negedge mclk) #1;
    spin = 1'b0;
    n = 0;
    while (so !== 1'b1 && n < 200) @(negedge mclk) n++;
    near("detect", n, 49, 54);
    check("stall out", st, 1'b1);
    check("stall only", st_so, 1'b1);
    check("tach only", st_to, 1'b1);
    check("tacho held", tp, 1'b1);
    check("phase a", pa, 1'b1);
    check("phase b", pb, 1'b0);
    n = 0;
    while ((pa | pb) !== 1'b0 && n < 30) @(negedge mclk) n++;
    n = 0;
    while ((pa | pb) === 1'b0 && n < 300) @(negedge mclk) n++;
    near("wait", n, 98, 102);
    n = 0;
    while ((pa | pb) === 1'b1 && n < 300) @(negedge mclk) n++;
    near("retry", n, 8, 12);
    spin = 1'b1;
    n = 0;
    while (so !== 1'b0 && n < 40) @(negedge mclk) n++;
    check("resume", so, 1'b0);
  endtask : stall
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    duty(tpfcl_pkg::TPFCL_SRC_VOLTAGE, 8'h80, 1'b0, 200);
    duty(tpfcl_pkg::TPFCL_SRC_VOLTAGE, 8'hA0, 1'b0, 150);
    duty(tpfcl_pkg::TPFCL_SRC_VOLTAGE, 8'hFF, 1'b0, 0);
    duty(tpfcl_pkg::TPFCL_SRC_OPEN, 8'h80, 1'b0, 100);
    duty(tpfcl_pkg::TPFCL_SRC_EXTERNAL, 8'hFF, 1'b1, 200);
    duty(tpfcl_pkg::TPFCL_SRC_EXTERNAL, 8'h80, 1'b0, 0);
    stall();
    results();
  end
endmodule : tb_top
